// file: mq_flag_status.sv
// Flag status outputs of a 16-queue FIFO device with an AXI4-Lite port
`timescale 1ns/1ps
module mq_flag_status (
	input wire logic sys_clk,
	input wire logic rst,
	// Device side
	input wire logic master_reset_n,
	input wire mq_pkg::mq_straps_s straps,
	input wire mq_pkg::mq_qstat_s qstat,
	input wire logic [7:0] read_queue_address,
	input wire logic read_address_enable,
	input wire logic read_flag_strobe,
	input wire logic [7:0] write_queue_address,
	input wire logic write_address_enable,
	output logic output_valid_n,
	output logic output_valid_oe,
	output logic almost_empty_flag_n,
	output logic packet_ready_flag_n,
	output logic almost_full_flag_n,
	output logic [7:0] read_side_flag_bus,
	output logic read_side_flag_bus_oe,
	output logic read_side_flag_sector,
	output logic irq,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ****************************************
	// Helpers
	// ****************************************

	// Port widths from the three width straps; one port is always x36
	function automatic mq_pkg::mq_widths_s width_decode(
		input mq_pkg::mq_straps_s st
	);
		mq_pkg::mq_widths_s w;
		w.in_w = mq_pkg::MQ_W36;
		w.out_w = mq_pkg::MQ_W36;
		if (st.bus_matching_select)
		begin
			unique case ({st.input_width_select, st.output_width_select})
				2'b00: w.in_w = mq_pkg::MQ_W18;
				2'b01: w.in_w = mq_pkg::MQ_W9;
				2'b10: w.out_w = mq_pkg::MQ_W18;
				2'b11: w.out_w = mq_pkg::MQ_W9;
			endcase
		end
		return w;
	endfunction : width_decode

	// Address is for this device when the top three bits match its id
	function automatic logic id_match(input logic [7:0] addr);
		return addr[7:5] == mq_pkg::DEVICE_ID;
	endfunction : id_match

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		mq_pkg::mq_straps_s straps; // Straps caught at master reset
		logic [3:0] rd_q; // Queue selected for reading
		logic rd_dev; // This device selected on read port
		logic [3:0] rd_p1; // Read selection, one stage later
		logic rd_p1v; // Device selection, one stage later
		logic ov_n;
		logic ov_oe;
		logic ae_n;
		logic pr_n;
		logic [7:0] rfb; // Read-side flag bus
		logic rfb_oe;
		logic sector; // Sector to load onto the bus
		logic rfb_sector; // Sector shown on the bus now
		logic bus_dev; // Device owns the flag bus (direct mode)
		logic [3:0] wr_q; // Queue selected for writing
		logic af_n;
		logic out_en; // Software drive enable for flag outputs
		logic [2:0] int_stat;
		logic [2:0] int_mask;
		logic irq;
		logic awready;
		logic wready;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} mq_state_s;

	mq_state_s st_ff; // Registered state
	mq_state_s nxt_st; // Next state
	mq_pkg::mq_widths_s widths; // Decoded port widths
	logic pkt_mode; // Packet mode in effect
	logic polled; // Polled flag-bus mode in effect
	logic [15:0] bus_src; // Status feeding the flag bus
	logic [31:0] status_word; // Read value of the status register
	logic [2:0] events; // One-cycle event pulses

	// ****************************************
	// Configuration decode
	// ****************************************

	// Packet mode only holds with both ports x36, else fall back
	always_comb
	begin
		widths = width_decode(st_ff.straps);
		pkt_mode = st_ff.straps.packet_mode_select
			&& widths.in_w == mq_pkg::MQ_W36
			&& widths.out_w == mq_pkg::MQ_W36;
		polled = st_ff.straps.flag_bus_mode_select;
		bus_src = pkt_mode ? qstat.packet_ready
			: qstat.almost_empty;
		status_word = 32'h0;
		status_word[mq_pkg::ST_IN_W_LSB +: 2] = widths.in_w;
		status_word[mq_pkg::ST_OUT_W_LSB +: 2] = widths.out_w;
		status_word[mq_pkg::ST_PKT_BIT] = pkt_mode;
		status_word[mq_pkg::ST_POLL_BIT] = polled;
		status_word[mq_pkg::ST_RDQ_LSB +: 4] = st_ff.rd_q;
		status_word[mq_pkg::ST_WRQ_LSB +: 4] = st_ff.wr_q;
		status_word[mq_pkg::ST_SECTOR_BIT] = st_ff.rfb_sector;
		status_word[mq_pkg::ST_OV_BIT] = st_ff.ov_n;
		status_word[mq_pkg::ST_AE_BIT] = st_ff.ae_n;
		status_word[mq_pkg::ST_AF_BIT] = st_ff.af_n;
	end

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb
	begin
		logic aw_have;
		logic w_have;
		logic [7:0] waddr;
		logic [31:0] wd;
		logic [3:0] ws;
		aw_have = 1'b0;
		w_have = 1'b0;
		waddr = 8'h0;
		wd = 32'h0;
		ws = 4'h0;
		nxt_st = st_ff;

		// Straps are followed while master reset is low, then frozen;
		// the host must keep them still afterwards
		if (!master_reset_n)
		begin
			nxt_st.straps = straps;
		end

		// Read port queue selection
		if (read_address_enable)
		begin
			nxt_st.rd_dev = id_match(read_queue_address);
			nxt_st.rd_q = read_queue_address[3:0];
		end

		// Selection walks one extra stage so the valid flag lags the
		// selection by two edges, matching the data path
		nxt_st.rd_p1 = st_ff.rd_q;
		nxt_st.rd_p1v = st_ff.rd_dev;
		nxt_st.ov_n = qstat.empty[st_ff.rd_p1];
		nxt_st.ov_oe = st_ff.rd_p1v && st_ff.out_en;

		// Discrete read flags follow the current read queue
		nxt_st.ae_n = !qstat.almost_empty[st_ff.rd_q];
		nxt_st.pr_n = !(pkt_mode && qstat.packet_ready[st_ff.rd_q]);

		// Sector selection: polled alternates, direct follows strobe
		if (polled)
		begin
			nxt_st.sector = !st_ff.sector;
			nxt_st.bus_dev = 1'b1;
		end
		else if (read_flag_strobe)
		begin
			nxt_st.sector = read_queue_address[3];
			nxt_st.bus_dev = id_match(read_queue_address);
		end

		// Bus carries inverted status of the chosen sector; the selected
		// queue's almost-empty (packet-ready in packet mode) shows on its line only while its sector is chosen
		nxt_st.rfb = st_ff.sector ? ~bus_src[15:8]
			: ~bus_src[7:0];
		nxt_st.rfb_sector = st_ff.sector;
		nxt_st.rfb_oe = st_ff.bus_dev && st_ff.out_en;

		// Write port queue selection and almost-full flag; the write
		// flag bus itself lives outside this block
		if (write_address_enable && id_match(write_queue_address))
		begin
			nxt_st.wr_q = write_queue_address[3:0];
		end
		nxt_st.af_n = !qstat.almost_full[st_ff.wr_q];

		// Master reset puts selection back to queue 0, sector 0
		if (!master_reset_n)
		begin
			nxt_st.rd_q = 4'h0;
			nxt_st.wr_q = 4'h0;
			nxt_st.sector = 1'b0;
		end

		// Write channel: address and data taken in either order
		if (st_ff.awready && s_axi_awvalid)
		begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = s_axi_awaddr;
		end
		if (st_ff.wready && s_axi_wvalid)
		begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = s_axi_wdata;
			nxt_st.wstrb = s_axi_wstrb;
		end
		aw_have = nxt_st.aw_got;
		w_have = nxt_st.w_got;
		waddr = nxt_st.awaddr;
		wd = nxt_st.wdata;
		ws = nxt_st.wstrb;

		// Events set sticky bits; a set in the clear cycle wins below
		events[mq_pkg::EV_EMPTY] = nxt_st.ov_n && !st_ff.ov_n;
		events[mq_pkg::EV_AFULL] = !nxt_st.af_n && st_ff.af_n;
		events[mq_pkg::EV_PRDY] = !nxt_st.pr_n && st_ff.pr_n;

		// Perform the write once both halves are in
		if (aw_have && w_have && !st_ff.bvalid)
		begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = mq_pkg::RESP_OKAY;
			unique case (waddr)
				mq_pkg::REG_CTRL:
				begin
					if (ws[0])
					begin
						nxt_st.out_en = wd[mq_pkg::CTRL_OUT_EN_BIT];
					end
				end
				mq_pkg::REG_STATUS:
				begin
					// Read-only; write is accepted and dropped
				end
				mq_pkg::REG_INT_STAT:
				begin
					if (ws[0])
					begin
						nxt_st.int_stat = st_ff.int_stat & ~wd[2:0];
					end
				end
				mq_pkg::REG_INT_MASK:
				begin
					if (ws[0])
					begin
						nxt_st.int_mask = wd[2:0];
					end
				end
				default:
				begin
					nxt_st.bresp = mq_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (st_ff.bvalid && s_axi_bready)
		begin
			nxt_st.bvalid = 1'b0;
		end
		nxt_st.int_stat = nxt_st.int_stat | events;
		nxt_st.irq = |(nxt_st.int_stat & nxt_st.int_mask);

		// Ready is dropped while a half is held or a response waits
		nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
		nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;

		// Read channel: one read at a time, answered next edge
		if (st_ff.arready && s_axi_arvalid)
		begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = mq_pkg::RESP_OKAY;
			nxt_st.rdata = 32'h0;
			unique case (s_axi_araddr)
				mq_pkg::REG_CTRL:
					nxt_st.rdata[mq_pkg::CTRL_OUT_EN_BIT] = st_ff.out_en;
				mq_pkg::REG_STATUS: nxt_st.rdata = status_word;
				mq_pkg::REG_INT_STAT: nxt_st.rdata[2:0] = st_ff.int_stat;
				mq_pkg::REG_INT_MASK: nxt_st.rdata[2:0] = st_ff.int_mask;
				default: nxt_st.rresp = mq_pkg::RESP_SLVERR;
			endcase
		end
		else if (st_ff.rvalid && s_axi_rready)
		begin
			nxt_st.rvalid = 1'b0;
		end
		nxt_st.arready = !nxt_st.rvalid;
	end

	// ****************************************
	// State register
	// ****************************************

	// Synchronous reset: flags inactive, outputs floated only until the device
	// selection loaded by reset reaches the enables (one edge for the flag bus,
	// two for output valid), bus ready to take requests
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			st_ff <= '0;
			st_ff.rd_dev <= 1'b1;
			st_ff.ov_n <= 1'b1;
			st_ff.ae_n <= 1'b1;
			st_ff.pr_n <= 1'b1;
			st_ff.af_n <= 1'b1;
			st_ff.rfb <= 8'hff;
			st_ff.bus_dev <= 1'b1;
			st_ff.out_en <= mq_pkg::CTRL_OUT_EN_RST;
			st_ff.int_mask <= mq_pkg::INT_MASK_RST;
			st_ff.awready <= 1'b1;
			st_ff.wready <= 1'b1;
			st_ff.arready <= 1'b1;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// Outputs, all straight from the state register
	// ****************************************
	assign output_valid_n = st_ff.ov_n;
	assign output_valid_oe = st_ff.ov_oe;
	assign almost_empty_flag_n = st_ff.ae_n;
	assign packet_ready_flag_n = st_ff.pr_n;
	assign almost_full_flag_n = st_ff.af_n;
	assign read_side_flag_bus = st_ff.rfb;
	assign read_side_flag_bus_oe = st_ff.rfb_oe;
	assign read_side_flag_sector = st_ff.rfb_sector;
	assign irq = st_ff.irq;
	assign s_axi_awready = st_ff.awready;
	assign s_axi_wready = st_ff.wready;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_arready = st_ff.arready;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;
	assign s_axi_rvalid = st_ff.rvalid;

endmodule : mq_flag_status

// file: mq_pkg.sv
// Package: constants, types and register map of the multi-queue flag block
package mq_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int NUM_QUEUES = 16; // Queues in one device
	localparam int SECTOR_SIZE = 8; // Queues per flag-bus sector
	localparam logic [2:0] DEVICE_ID = 3'h0; // Arbitrary, single-device id

	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_INT_STAT = 8'h08;
	localparam logic [7:0] REG_INT_MASK = 8'h0c;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int CTRL_OUT_EN_BIT = 0; // Flag output drive enable
	localparam logic CTRL_OUT_EN_RST = 1'h1;
	localparam int ST_IN_W_LSB = 0; // Input width code, 2 bits
	localparam int ST_OUT_W_LSB = 2; // Output width code, 2 bits
	localparam int ST_PKT_BIT = 4;
	localparam int ST_POLL_BIT = 5;
	localparam int ST_RDQ_LSB = 6; // Read queue, 4 bits
	localparam int ST_WRQ_LSB = 10; // Write queue, 4 bits
	localparam int ST_SECTOR_BIT = 14;
	localparam int ST_OV_BIT = 15;
	localparam int ST_AE_BIT = 16;
	localparam int ST_AF_BIT = 17;
	localparam int NUM_EVENTS = 3;
	localparam int EV_EMPTY = 0; // Selected read queue went invalid
	localparam int EV_AFULL = 1; // Selected write queue went almost full
	localparam int EV_PRDY = 2; // Selected read queue has a packet
	localparam logic [2:0] INT_MASK_RST = 3'h0;

	// ****************************************
	// Bus responses
	// ****************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Port width codes
	// ****************************************
	typedef enum logic [1:0] {
		MQ_W9 = 2'b00,
		MQ_W18 = 2'b01,
		MQ_W36 = 2'b10
	} mq_width_e;

	typedef struct packed {
		mq_width_e in_w;
		mq_width_e out_w;
	} mq_widths_s;

	// Per-queue status from the queue memory, bit n is queue n
	typedef struct packed {
		logic [15:0] empty;
		logic [15:0] almost_empty;
		logic [15:0] packet_ready;
		logic [15:0] almost_full;
	} mq_qstat_s;

	// Configuration straps caught at master reset
	typedef struct packed {
		logic output_width_select;
		logic input_width_select;
		logic bus_matching_select;
		logic packet_mode_select;
		logic flag_bus_mode_select;
	} mq_straps_s;

endpackage : mq_pkg

// file: mq_host_model.sv
// Host model: picks read and write queues and strobes the flag bus
`timescale 1ns/1ps
module mq_host_model #(
	parameter int SEED = 5
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wild, // High: some selects name a foreign device
	output logic [7:0] read_queue_address,
	output logic read_address_enable,
	output logic read_flag_strobe,
	output logic [7:0] write_queue_address,
	output logic write_address_enable
);
	int sd = SEED;
	// ****************************************
	// Random selections, changed just after each edge
	// ****************************************
	always @(posedge sys_clk)
	begin : pick
		logic [31:0] r;
		r = $random(sd);
		if (rst)
		begin
			read_address_enable <= 1'b0;
			read_flag_strobe <= 1'b0;
			write_address_enable <= 1'b0;
		end
		else
		begin
			// Foreign ids only when asked, so deselection stays rare
			read_queue_address <= {wild & r[5] ? 3'h1 : 3'h0, 1'b0, r[3:0]};
			read_address_enable <= r[8];
			read_flag_strobe <= r[9];
			write_queue_address <= {wild & r[12] ? 3'h2 : 3'h0, 1'b0, r[19:16]};
			write_address_enable <= r[10];
		end
	end
	initial
	begin
		read_queue_address = 8'h00;
		read_address_enable = 1'b0;
		read_flag_strobe = 1'b0;
		write_queue_address = 8'h00;
		write_address_enable = 1'b0;
	end
endmodule : mq_host_model

// file: mq_flag_status_monitor.sv
// Checker of the flag outputs against the selected queues
`timescale 1ns/1ps
module mq_flag_status_monitor (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic master_reset_n,
	input wire mq_pkg::mq_straps_s straps,
	input wire mq_pkg::mq_qstat_s qstat,
	input wire logic [7:0] read_queue_address,
	input wire logic read_address_enable,
	input wire logic read_flag_strobe,
	input wire logic [7:0] write_queue_address,
	input wire logic write_address_enable,
	input wire logic output_valid_n,
	input wire logic output_valid_oe,
	input wire logic almost_empty_flag_n,
	input wire logic packet_ready_flag_n,
	input wire logic almost_full_flag_n,
	input wire logic [7:0] read_side_flag_bus,
	input wire logic read_side_flag_bus_oe,
	input wire logic read_side_flag_sector
);
	// Shadow of the selected queues; rq1 is the read queue one edge on
	logic [3:0] rq, rq1, wq;
	logic rdv, pol, pkt; // Device selected, polled, packet in effect
	logic eae, eaf, eov; // Flag values: eae, eaf one edge after selection, eov two edges after
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Shadow selection; straps follow while master reset is low
	always_ff @(posedge sys_clk)
	begin
		if (rst || !master_reset_n)
		begin
			rq <= 4'h0;
			wq <= 4'h0;
			rdv <= 1'b1;
			pol <= straps.flag_bus_mode_select;
			pkt <= straps.packet_mode_select & !straps.bus_matching_select;
		end
		else
		begin
			if (read_address_enable)
			begin
				// The queue field is taken even for a foreign id
				rdv <= read_queue_address[7:5] == 3'h0;
				rq <= read_queue_address[3:0];
			end
			if (write_address_enable && write_queue_address[7:5] == 3'h0)
				wq <= write_queue_address[3:0];
		end
	end
	always_ff @(posedge sys_clk)
	begin
		eae <= !qstat.almost_empty[rq];
		eaf <= !qstat.almost_full[wq];
		rq1 <= rq;
		// Valid flag looks at the queue chosen two edges back
		eov <= qstat.empty[rq1];
	end
	sequence s_run;
		master_reset_n && $past(master_reset_n) && $past(master_reset_n, 2);
	endsequence
	sequence s_calm;
		($stable(qstat) && master_reset_n) [*3];
	endsequence
	sequence s_pick;
		!pol && master_reset_n && read_flag_strobe && read_queue_address[7:5] == 3'h0;
	endsequence
	sequence s_far;
		!pol && master_reset_n && read_flag_strobe
			&& read_queue_address[7:5] != 3'h0;
	endsequence
	a_ae_follows: assert property (s_run ##0 rdv |-> almost_empty_flag_n == eae)
		else $error("almost empty flag off its queue");
	a_ov_lags_two: assert property (s_run ##0 rdv && $past(rdv) |-> output_valid_n == eov)
		else $error("output valid flag off its queue");
	a_af_follows: assert property (s_run |-> almost_full_flag_n == eaf)
		else $error("almost full flag off its queue");
	a_poll_alternates: assert property (s_run ##0 pol |-> read_side_flag_sector != $past(read_side_flag_sector))
		else $error("polled sector did not alternate");
	a_bus_status: assert property (s_calm |-> read_side_flag_bus == (pkt ? ~qstat.packet_ready[{read_side_flag_sector, 3'h0} +: 8] : ~qstat.almost_empty[{read_side_flag_sector, 3'h0} +: 8]))
		else $error("flag bus content wrong");
	a_direct_sector: assert property (s_pick |-> ##2 read_side_flag_sector == $past(read_queue_address[3], 2))
		else $error("direct sector not shown");
	a_ov_floats: assert property (master_reset_n && read_address_enable && read_queue_address[7:5] != 3'h0 |-> ##3 !output_valid_oe)
		else $error("output valid still driven");
	a_bus_floats: assert property (s_far |-> ##2 !read_side_flag_bus_oe)
		else $error("flag bus still driven");
	a_pr_idle: assert property (s_run ##0 !pkt |-> packet_ready_flag_n)
		else $error("packet ready active outside packet mode");
endmodule : mq_flag_status_monitor
bind mq_flag_status mq_flag_status_monitor mq_flag_status_monitor_i (
	.sys_clk(sys_clk), .rst(rst), .master_reset_n(master_reset_n),
	.straps(straps), .qstat(qstat),
	.read_queue_address(read_queue_address),
	.read_address_enable(read_address_enable),
	.read_flag_strobe(read_flag_strobe),
	.write_queue_address(write_queue_address),
	.write_address_enable(write_address_enable),
	.output_valid_n(output_valid_n), .output_valid_oe(output_valid_oe),
	.almost_empty_flag_n(almost_empty_flag_n),
	.packet_ready_flag_n(packet_ready_flag_n),
	.almost_full_flag_n(almost_full_flag_n),
	.read_side_flag_bus(read_side_flag_bus),
	.read_side_flag_bus_oe(read_side_flag_bus_oe),
	.read_side_flag_sector(read_side_flag_sector)
);

// file: multiqueue_flag_status_outputs_tb.sv
// Testbench of the multi-queue flag block
`timescale 1ns/1ps
module multiqueue_flag_status_outputs_tb;
	logic sys_clk = 1'b0, rst = 1'b1, master_reset_n = 1'b0, wild = 1'b0;
	mq_pkg::mq_straps_s straps = '0;
	mq_pkg::mq_qstat_s qstat = '0;
	logic [7:0] rqa, wqa, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic rae, rfs, wae, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [65:0] expq[$]; // Notes of {resp, mask, data}
	logic [4:0] cfg[6] = '{5'h00, 5'h03, 5'h06, 5'h0d, 5'h14, 5'h1e};
	logic [5:0] cfg_exp[6] = '{6'h0a, 6'h3a, 6'h09, 6'h26, 6'h08, 6'h02};
	int n_mismatch = 0, comparisons = 0, seed = 48;
	initial forever #2.5 sys_clk = ~sys_clk;
	mq_host_model mq_host_model_i (.sys_clk(sys_clk), .rst(rst), .wild(wild),
		.read_queue_address(rqa), .read_address_enable(rae),
		.read_flag_strobe(rfs), .write_queue_address(wqa),
		.write_address_enable(wae));
	mq_flag_status mq_flag_status_i (.sys_clk(sys_clk), .rst(rst),
		.master_reset_n(master_reset_n), .straps(straps), .qstat(qstat),
		.read_queue_address(rqa), .read_address_enable(rae),
		.read_flag_strobe(rfs), .write_queue_address(wqa),
		.write_address_enable(wae), .output_valid_n(), .output_valid_oe(),
		.almost_empty_flag_n(), .packet_ready_flag_n(),
		.almost_full_flag_n(), .read_side_flag_bus(),
		.read_side_flag_bus_oe(), .read_side_flag_sector(), .irq(irq),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	task automatic results;
		if (n_mismatch == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [31:0] ex, got);
		comparisons++;
		if (got !== ex)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	// Write: both halves offered together, each dropped when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		bit aw, w, b;
		aw = 0;
		w = 0;
		b = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Ready stays up between calls; only the watchdog ends a wait
		while (!b)
		begin
			@(posedge sys_clk);
			if (!aw && s_axi_awready) begin aw = 1; s_axi_awvalid <= 1'b0; end
			if (!w && s_axi_wready) begin w = 1; s_axi_wvalid <= 1'b0; end
			if (s_axi_bvalid) b = 1;
		end
	endtask : axw
	// Read: the note goes on the queue, the watcher compares
	task automatic axr(input logic [7:0] a, input logic [31:0] m, e,
		input logic [1:0] r);
		bit ar, b;
		ar = 0;
		b = 0;
		expq.push_back({r, m, e});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!b)
		begin
			@(posedge sys_clk);
			if (!ar && s_axi_arready) begin ar = 1; s_axi_arvalid <= 1'b0; end
			if (s_axi_rvalid) b = 1;
		end
	endtask : axr
	// Watcher: each read answer is matched with the oldest note
	always @(posedge sys_clk)
	begin : watch
		logic [65:0] e;
		if (s_axi_rvalid && s_axi_rready)
		begin
			e = expq.size() ? expq.pop_front() : '1;
			chk("rdata", e[31:0], s_axi_rdata & e[63:32]);
			chk("rresp", {30'h0, e[65:64]}, {30'h0, s_axi_rresp});
		end
	end
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		results();
	end
	initial
	begin
		cyc(6);
		rst <= 1'b0;
		cyc(1);
		master_reset_n <= 1'b1;
		cyc(2);
		axr(mq_pkg::REG_CTRL, 32'h1, 32'h1, mq_pkg::RESP_OKAY);
		axr(mq_pkg::REG_INT_MASK, 32'h7, 32'h0, mq_pkg::RESP_OKAY);
		axr(8'h10, 32'hffffffff, 32'h0, mq_pkg::RESP_SLVERR);
		axw(mq_pkg::REG_INT_STAT, 32'h7);
		axw(mq_pkg::REG_INT_MASK, 32'h1);
		axr(mq_pkg::REG_INT_MASK, 32'h7, 32'h1, mq_pkg::RESP_OKAY);
		qstat.empty <= 16'hffff;
		cyc(8);
		chk("irq", 32'h1, {31'h0, irq});
		axr(mq_pkg::REG_INT_STAT, 32'h1, 32'h1, mq_pkg::RESP_OKAY);
		qstat.empty <= 16'h0000;
		cyc(4);
		axw(mq_pkg::REG_INT_STAT, 32'h1);
		axr(mq_pkg::REG_INT_STAT, 32'h1, 32'h0, mq_pkg::RESP_OKAY);
		chk("irq", 32'h0, {31'h0, irq});
		axw(mq_pkg::REG_INT_MASK, 32'h0);
		qstat.empty <= 16'hffff;
		cyc(8);
		chk("irq", 32'h0, {31'h0, irq});
		for (int i = 0; i < 6; i++)
		begin
			master_reset_n <= 1'b0;
			straps <= cfg[i];
			cyc(2);
			master_reset_n <= 1'b1;
			cyc(2);
			axr(mq_pkg::REG_STATUS, 32'h3f, {26'h0, cfg_exp[i]}, mq_pkg::RESP_OKAY);
			wild <= 1'b1;
			for (int k = 0; k < 60; k++)
			begin
				qstat <= {$random(seed), $random(seed)};
				cyc(k % 2 ? 5 : 1);
			end
			wild <= 1'b0;
			cyc(6);
		end
		results();
	end
endmodule : multiqueue_flag_status_outputs_tb
